// file: hdl/tof_cfg_pkg.sv
// constants and types shared by the emitter and trigger configuration block
package tof_cfg_pkg;
   // register addresses on the control port
   localparam logic [7:0] ADDR_FRAME_DELAY = 8'h26;
   localparam logic [7:0] ADDR_SINGLE_SHOT = 8'h27;
   localparam logic [7:0] ADDR_CURRENT_CODES = 8'h29;
   localparam logic [7:0] ADDR_CHANNEL_CTRL = 8'h2A;
   localparam logic [7:0] ADDR_UPPER_LIMIT = 8'h2B;
   localparam logic [7:0] ADDR_LOWER_LIMIT = 8'h2C;
   // values after reset
   localparam logic [23:0] RST_FRAME_DELAY = 24'h04000F;
   localparam logic [23:0] RST_SINGLE_SHOT = 24'h26AC18;
   localparam logic [23:0] RST_CURRENT_CODES = 24'h3F0FC3;
   localparam logic [23:0] RST_CHANNEL_CTRL = 24'h784920;
   localparam logic [15:0] RST_UPPER_LIMIT = 16'h6000;
   localparam logic [15:0] RST_LOWER_LIMIT = 16'h0800;
   // field positions
   localparam int FSD_LSB = 10;
   localparam int FSD_W = 14;
   localparam int FREEZE_LSB = 8;
   localparam int SAMPLES_LSB = 2;
   localparam int MODE_LSB = 0;
   localparam int CH0_LOW_LSB = 0;
   localparam int CH0_HIGH_LSB = 5;
   localparam int CH1_LOW_LSB = 10;
   localparam int CH1_HIGH_LSB = 15;
   localparam int CH2_LOW_UPPER_LSB = 20;
   localparam int CH2_LOW_LSB_BIT = 23;
   localparam int CH2_HIGH_LSB = 18;
   localparam int RSVD_CTRL_BIT = 17;
   localparam int FIXED_CURRENT_BIT = 16;
   localparam int AUTO_SWITCH_BIT = 15;
   localparam int ROT_PATTERN_LSB = 3;
   localparam int FIXED_EMITTER_LSB = 1;
   localparam int ROT_ENABLE_BIT = 0;
   // trigger modes
   localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h3;
   // timing: internal clock period and system clock period in ns
   localparam int unsigned DELAY_MULT = 64;
   localparam int unsigned DELAY_ADD = 2;
   localparam int unsigned T_INT_CLK_NS = 25;
   localparam int unsigned T_SYS_CLK_NS = 10;
   localparam logic [4:0] TICK_STEP = 5'h0A;
   localparam logic [4:0] TICK_WRAP = 5'h19;
   localparam logic [2:0] ROT_SLOTS = 3'h6;
   typedef enum logic [1:0] {ACQ_IDLE, ACQ_DELAY, ACQ_RUN, ACQ_FROZEN} acq_state_t;
endpackage

// file: hdl/frame_delay_timer.sv
// down counter that pulses done a programmed number of cycles after start
module frame_delay_timer
   import tof_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [31:0] load_cycles,
   output logic done,
   output logic busy
);
   logic [31:0] cnt_r;

   // a load of zero still waits one cycle, so done is never lost
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_r <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         cnt_r <= (load_cycles == 32'h0) ? 32'h1 : load_cycles;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy) begin
         cnt_r <= cnt_r - 32'h1;
         done <= (cnt_r == 32'h1);
         busy <= (cnt_r != 32'h1);
      end else begin
         done <= 1'b0;
      end
   end

   timer_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      busy && !start && cnt_r > 32'h1 |=> !done && busy)
      else $error("delay timer finished early");
   timer_end_a: assert property (@(posedge sys_clk) disable iff (reset)
      busy && !start && cnt_r == 32'h1 |=> done && !busy)
      else $error("delay timer did not finish at the count");
endmodule

// file: hdl/current_level_ctrl.sv
// chooses low or high drive current, fixed or by received amplitude
module current_level_ctrl
   import tof_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic auto_current_switch_enable,
   input wire logic fixed_current_select,
   input wire logic [15:0] amplitude,
   input wire logic amplitude_valid,
   input wire logic [15:0] amplitude_upper_limit,
   input wire logic [15:0] amplitude_lower_limit,
   output logic use_high_r
);
   // hysteresis between the two limits keeps the level from chattering
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         use_high_r <= 1'b0;
      end else if (!auto_current_switch_enable) begin
         use_high_r <= fixed_current_select;
      end else if (amplitude_valid) begin
         if (use_high_r && amplitude > amplitude_upper_limit) begin
            use_high_r <= 1'b0;
         end else if (!use_high_r && amplitude < amplitude_lower_limit) begin
            use_high_r <= 1'b1;
         end
      end
   end

   fixed_level_a: assert property (@(posedge sys_clk) disable iff (reset)
      !auto_current_switch_enable |=> use_high_r == $past(fixed_current_select))
      else $error("fixed current select not followed");
   drop_to_low_a: assert property (@(posedge sys_clk) disable iff (reset)
      auto_current_switch_enable && amplitude_valid && use_high_r
      && amplitude > amplitude_upper_limit |=> !use_high_r)
      else $error("high current kept above upper limit");
   rise_to_high_a: assert property (@(posedge sys_clk) disable iff (reset)
      auto_current_switch_enable && amplitude_valid && !use_high_r
      && amplitude < amplitude_lower_limit |=> use_high_r)
      else $error("low current kept below lower limit");
   no_switch_a: assert property (@(posedge sys_clk) disable iff (reset)
      auto_current_switch_enable && !amplitude_valid |=> $stable(use_high_r))
      else $error("current level moved without an amplitude");
endmodule

// file: hdl/emitter_trigger_cfg.sv
// configuration registers, single-shot sequencing and emitter selection
// Functional notes
// - strobe waits (64*delay+2) ticks of 25 ns
// - single-shot freezes at programmed tick count
// - each trigger captures programmed sample count
// - mode 0 continuous, mode 3 single-shot
// - channel 0 low/high codes, bits 4:0, 9:5
// - channel 1 low/high codes, bits 14:10, 19:15
// - channel 2 low code split over two registers
// - channel 2 high code in bits 22:18
// - fixed select picks low or high code
// - auto switching enable follows amplitude
// - rotation pattern, six slots, resets 924h
// - rotation applies least significant slot first
// - fixed emitter select when rotation off
// - rotation enable chooses pattern or fixed select
// - high current drops low above upper limit
// - low current rises high below lower limit
module emitter_trigger_cfg
   import tof_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata_r,
   output logic reg_rvalid_r,
   input wire logic single_shot_trigger,
   input wire logic frame_end,
   input wire logic [15:0] amplitude,
   input wire logic amplitude_valid,
   output logic frame_start_strobe_r,
   output logic frozen_r,
   output logic acq_busy_r,
   output logic [1:0] emitter_select_r,
   output logic drive_high_r,
   output logic [4:0] drive_current_code_r
);
   logic [23:0] frame_delay_cfg_r;
   logic [23:0] single_shot_cfg_r;
   logic [23:0] current_codes_r;
   logic [23:0] channel_ctrl_r;
   logic [15:0] upper_limit_r;
   logic [15:0] lower_limit_r;

   // register writes; every field is plain read/write storage
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         frame_delay_cfg_r <= RST_FRAME_DELAY;
         single_shot_cfg_r <= RST_SINGLE_SHOT;
         current_codes_r <= RST_CURRENT_CODES;
         channel_ctrl_r <= RST_CHANNEL_CTRL;
         upper_limit_r <= RST_UPPER_LIMIT;
         lower_limit_r <= RST_LOWER_LIMIT;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_FRAME_DELAY: frame_delay_cfg_r <= reg_wdata; // kept as written
            ADDR_SINGLE_SHOT: single_shot_cfg_r <= reg_wdata;
            ADDR_CURRENT_CODES: current_codes_r <= reg_wdata;
            ADDR_CHANNEL_CTRL: channel_ctrl_r <= reg_wdata; // kept as written
            ADDR_UPPER_LIMIT: upper_limit_r <= reg_wdata[15:0];
            ADDR_LOWER_LIMIT: lower_limit_r <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // registered read port; unmapped addresses read zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata_r <= 24'h0;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               ADDR_FRAME_DELAY: reg_rdata_r <= frame_delay_cfg_r;
               ADDR_SINGLE_SHOT: reg_rdata_r <= single_shot_cfg_r;
               ADDR_CURRENT_CODES: reg_rdata_r <= current_codes_r;
               ADDR_CHANNEL_CTRL: reg_rdata_r <= channel_ctrl_r;
               ADDR_UPPER_LIMIT: reg_rdata_r <= {8'h00, upper_limit_r};
               ADDR_LOWER_LIMIT: reg_rdata_r <= {8'h00, lower_limit_r};
               default: reg_rdata_r <= 24'h0;
            endcase
         end
      end
   end

   // field views
   logic [FSD_W-1:0] frame_start_delay;
   logic [15:0] single_shot_freeze_count;
   logic [5:0] single_shot_sample_count;
   logic [1:0] trigger_mode;
   logic fixed_current_select;
   logic auto_current_switch_enable;
   logic [11:0] emitter_rotation_pattern;
   logic [1:0] fixed_emitter_select;
   logic rotation_enable;
   assign frame_start_delay = frame_delay_cfg_r[FSD_LSB +: FSD_W];
   assign single_shot_freeze_count = single_shot_cfg_r[FREEZE_LSB +: 16];
   assign single_shot_sample_count = single_shot_cfg_r[SAMPLES_LSB +: 6];
   assign trigger_mode = single_shot_cfg_r[MODE_LSB +: 2];
   assign fixed_current_select = channel_ctrl_r[FIXED_CURRENT_BIT];
   assign auto_current_switch_enable = channel_ctrl_r[AUTO_SWITCH_BIT];
   assign emitter_rotation_pattern = channel_ctrl_r[ROT_PATTERN_LSB +: 12];
   assign fixed_emitter_select = channel_ctrl_r[FIXED_EMITTER_LSB +: 2];
   assign rotation_enable = channel_ctrl_r[ROT_ENABLE_BIT];

   // per-channel current codes; channel 2 low code straddles two registers
   logic [4:0] low_code [3];
   logic [4:0] high_code [3];
   assign low_code[0] = current_codes_r[CH0_LOW_LSB +: 5];
   assign high_code[0] = current_codes_r[CH0_HIGH_LSB +: 5];
   assign low_code[1] = current_codes_r[CH1_LOW_LSB +: 5];
   assign high_code[1] = current_codes_r[CH1_HIGH_LSB +: 5];
   assign low_code[2] = {current_codes_r[CH2_LOW_UPPER_LSB +: 4],
                         channel_ctrl_r[CH2_LOW_LSB_BIT]};
   assign high_code[2] = channel_ctrl_r[CH2_HIGH_LSB +: 5];

   // rotation slots, slot 0 is the least significant pair
   logic [1:0] slot_code [6];
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_slot
         assign slot_code[g] = emitter_rotation_pattern[2*g +: 2];
      end
   endgenerate

   // delay from trigger to frame start, rounded up to whole system cycles
   logic [31:0] delay_ns;
   logic [31:0] delay_cycles;
   assign delay_ns = (DELAY_MULT * {18'h0, frame_start_delay} + DELAY_ADD) * T_INT_CLK_NS;
   assign delay_cycles = (delay_ns + T_SYS_CLK_NS - 1) / T_SYS_CLK_NS;

   acq_state_t state_r;
   acq_state_t state_nxt;
   logic timer_start;
   logic timer_done;
   logic timer_busy;
   logic strobe_nxt;
   logic [5:0] samples_r;
   logic [4:0] tick_acc_r;
   logic tick_r;
   logic [15:0] int_clk_cnt_r;
   logic use_high;

   frame_delay_timer u_delay (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(timer_start),
      .load_cycles(delay_cycles),
      .done(timer_done),
      .busy(timer_busy)
   );

   current_level_ctrl u_level (
      .sys_clk(sys_clk),
      .reset(reset),
      .auto_current_switch_enable(auto_current_switch_enable),
      .fixed_current_select(fixed_current_select),
      .amplitude(amplitude),
      .amplitude_valid(amplitude_valid),
      .amplitude_upper_limit(upper_limit_r),
      .amplitude_lower_limit(lower_limit_r),
      .use_high_r(use_high)
   );

   // 25 ns internal clock derived from the 10 ns clock by a fractional step
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tick_acc_r <= 5'h00;
         tick_r <= 1'b0;
      end else if (tick_acc_r + TICK_STEP >= TICK_WRAP) begin
         tick_acc_r <= tick_acc_r + TICK_STEP - TICK_WRAP;
         tick_r <= 1'b1;
      end else begin
         tick_acc_r <= tick_acc_r + TICK_STEP;
         tick_r <= 1'b0;
      end
   end

   logic freeze_hit;
   assign freeze_hit = (int_clk_cnt_r == single_shot_freeze_count);

   // acquisition sequencing; invalid modes park the sequencer in idle
   always_comb begin
      state_nxt = state_r;
      timer_start = 1'b0;
      strobe_nxt = 1'b0;
      unique case (state_r)
         ACQ_IDLE, ACQ_FROZEN: begin
            if (trigger_mode == MODE_CONTINUOUS) begin
               state_nxt = ACQ_RUN;
               strobe_nxt = 1'b1;
            end else if (trigger_mode == MODE_SINGLE && single_shot_trigger) begin
               state_nxt = ACQ_DELAY;
               timer_start = 1'b1;
            end else if (trigger_mode != MODE_SINGLE) begin
               state_nxt = ACQ_IDLE;
            end
         end
         ACQ_DELAY: begin
            if (trigger_mode != MODE_SINGLE) begin
               state_nxt = ACQ_IDLE;
            end else if (freeze_hit) begin
               state_nxt = ACQ_FROZEN;
            end else if (timer_done) begin
               state_nxt = ACQ_RUN;
               strobe_nxt = 1'b1;
            end
         end
         ACQ_RUN: begin
            if (trigger_mode == MODE_CONTINUOUS) begin
               strobe_nxt = frame_end;
            end else if (trigger_mode != MODE_SINGLE) begin
               state_nxt = ACQ_IDLE;
            end else if (freeze_hit) begin
               state_nxt = ACQ_FROZEN;
            end else if (frame_end) begin
               if (samples_r + 6'h01 >= single_shot_sample_count) begin
                  state_nxt = ACQ_IDLE;
               end else begin
                  strobe_nxt = 1'b1;
               end
            end
         end
      endcase
   end

   // state, strobe and sample progress
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= ACQ_IDLE;
         frame_start_strobe_r <= 1'b0;
         frozen_r <= 1'b0;
         acq_busy_r <= 1'b0;
         samples_r <= 6'h00;
      end else begin
         state_r <= state_nxt;
         frame_start_strobe_r <= strobe_nxt;
         frozen_r <= (state_nxt == ACQ_FROZEN);
         acq_busy_r <= (state_nxt == ACQ_DELAY) || (state_nxt == ACQ_RUN);
         if (timer_start) begin
            samples_r <= 6'h00;
         end else if (state_r == ACQ_RUN && frame_end) begin
            samples_r <= samples_r + 6'h01;
         end
      end
   end

   // internal clock count since the single-shot trigger
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         int_clk_cnt_r <= 16'h0000;
      end else if (timer_start) begin
         int_clk_cnt_r <= 16'h0000;
      end else if (tick_r && (state_r == ACQ_DELAY || state_r == ACQ_RUN)) begin
         int_clk_cnt_r <= int_clk_cnt_r + 16'h0001;
      end
   end

   // emitter choice: rotation steps once per frame, else fixed select
   logic [2:0] slot_r;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         slot_r <= 3'h0;
         emitter_select_r <= 2'h0;
      end else if (!rotation_enable) begin
         slot_r <= 3'h0;
         emitter_select_r <= fixed_emitter_select;
      end else if (strobe_nxt) begin
         emitter_select_r <= slot_code[slot_r];
         slot_r <= (slot_r == ROT_SLOTS - 3'h1) ? 3'h0 : slot_r + 3'h1;
      end
   end

   // drive code follows the chosen channel and current level; code 3 reads 0
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         drive_high_r <= 1'b0;
         drive_current_code_r <= 5'h00;
      end else begin
         drive_high_r <= use_high;
         if (emitter_select_r == 2'h3) begin
            drive_current_code_r <= 5'h00;
         end else begin
            drive_current_code_r <= use_high ? high_code[emitter_select_r]
                                             : low_code[emitter_select_r];
         end
      end
   end

   single_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
      state_r == ACQ_DELAY && !timer_done |=> !frame_start_strobe_r)
      else $error("frame start came before the delay ran out");
   delay_busy_a: assert property (@(posedge sys_clk) disable iff (reset)
      state_r == ACQ_DELAY && !timer_done |-> timer_busy)
      else $error("delay state without a running timer");
   freeze_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
      trigger_mode == MODE_SINGLE && (state_r == ACQ_DELAY || state_r == ACQ_RUN) && freeze_hit
      |=> frozen_r && !acq_busy_r)
      else $error("single shot did not freeze at the count");
   sample_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
      trigger_mode == MODE_SINGLE && state_r == ACQ_RUN && !freeze_hit && frame_end
      && samples_r + 6'h01 >= single_shot_sample_count |=> !frame_start_strobe_r)
      else $error("frame started past the sample count");
   mode_cont_a: assert property (@(posedge sys_clk) disable iff (reset)
      trigger_mode == MODE_CONTINUOUS && state_r == ACQ_RUN && frame_end
      |=> frame_start_strobe_r)
      else $error("continuous mode did not restart a frame");
   fixed_emit_a: assert property (@(posedge sys_clk) disable iff (reset)
      !rotation_enable |=> emitter_select_r == $past(fixed_emitter_select))
      else $error("fixed emitter select not followed");
   rot_order_a: assert property (@(posedge sys_clk) disable iff (reset)
      rotation_enable && strobe_nxt |=> emitter_select_r == $past(slot_code[slot_r]))
      else $error("rotation slot not applied");
   rot_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
      rotation_enable && strobe_nxt && slot_r == 3'h5 |=> slot_r == 3'h0)
      else $error("rotation did not wrap after six slots");
   code_pick_a: assert property (@(posedge sys_clk) disable iff (reset)
      emitter_select_r == 2'h0 && !use_high && $stable(emitter_select_r)
      |=> drive_current_code_r == $past(low_code[0]))
      else $error("channel 0 low code not driven");
endmodule

// file: testbench/tb.sv
// self-checking bench for the emitter and trigger configuration block
module tb
   import tof_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk;
   logic reset;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [23:0] reg_wdata;
   logic [23:0] reg_rdata_r;
   logic reg_rvalid_r;
   logic single_shot_trigger;
   logic frame_end;
   logic [15:0] amplitude;
   logic amplitude_valid;
   logic frame_start_strobe_r;
   logic frozen_r;
   logic acq_busy_r;
   logic [1:0] emitter_select_r;
   logic drive_high_r;
   logic [4:0] drive_current_code_r;
   int bad_count = 0;
   int compares = 0;

   emitter_trigger_cfg emitter_trigger_cfg_i (
      .sys_clk(sys_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r),
      .reg_rvalid_r(reg_rvalid_r),
      .single_shot_trigger(single_shot_trigger),
      .frame_end(frame_end),
      .amplitude(amplitude),
      .amplitude_valid(amplitude_valid),
      .frame_start_strobe_r(frame_start_strobe_r),
      .frozen_r(frozen_r),
      .acq_busy_r(acq_busy_r),
      .emitter_select_r(emitter_select_r),
      .drive_high_r(drive_high_r),
      .drive_current_code_r(drive_current_code_r)
   );

   // 100 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // verdict in one place, also reached when a wait runs out
   task automatic close_out();
      $display("counts: compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // all drivers start at a falling edge and hold through one rising edge
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // let an edge pass so a following call never re-raises the strobe at once
      @(negedge sys_clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk(reg_rvalid_r, 24'h000001);
      chk(reg_rdata_r, exp);
      @(negedge sys_clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask

   // strobe must follow the frame end at once and stand for one cycle only
   task automatic fe_strobe(output logic s);
      pulse(frame_end);
      s = frame_start_strobe_r;
      tick(1);
      s = s & ~frame_start_strobe_r;
   endtask

   task automatic amp(input logic [15:0] v, input logic e);
      amplitude = v;
      amplitude_valid = 1'b1;
      @(negedge sys_clk);
      amplitude_valid = 1'b0;
      tick(3);
      chk(drive_high_r, e);
      chk(drive_current_code_r, e ? 24'h2 : 24'h1);
   endtask

   task automatic t_reset();
      rd_chk(ADDR_FRAME_DELAY, 24'h04000F);
      rd_chk(ADDR_SINGLE_SHOT, 24'h26AC18);
      rd_chk(ADDR_CURRENT_CODES, 24'h3F0FC3);
      rd_chk(ADDR_CHANNEL_CTRL, 24'h784920);
      rd_chk(ADDR_UPPER_LIMIT, 24'h006000);
      rd_chk(ADDR_LOWER_LIMIT, 24'h000800);
      rd_chk(8'h30, 24'h000000);
      $display("test reset_values done");
   endtask

   // low code of channel c is 2c+1, high code 2c+2
   task automatic t_codes();
      wr(ADDR_CURRENT_CODES, 24'h220C41);
      rd_chk(ADDR_CURRENT_CODES, 24'h220C41);
      for (int ch = 0; ch < 3; ch++) begin
         for (int lv = 0; lv < 2; lv++) begin
            wr(ADDR_CHANNEL_CTRL, 24'h980000 | (lv << 16) | (ch << 1));
            tick(4);
            chk(emitter_select_r, ch);
            chk(drive_high_r, lv);
            chk(drive_current_code_r, 2 * ch + 1 + lv);
         end
      end
      $display("test current_codes done");
   endtask

   task automatic t_auto();
      wr(ADDR_UPPER_LIMIT, 24'h001000);
      wr(ADDR_LOWER_LIMIT, 24'h000100);
      wr(ADDR_CHANNEL_CTRL, 24'h990000);
      tick(4);
      amp(16'hFFFF, 1'b1);
      wr(ADDR_CHANNEL_CTRL, 24'h988000);
      tick(4);
      chk(drive_high_r, 24'h1);
      amp(16'h1000, 1'b1);
      amp(16'h1001, 1'b0);
      amp(16'h0100, 1'b0);
      amp(16'h00FF, 1'b1);
      $display("test auto_switch done");
   endtask

   task automatic t_single();
      int n;
      logic s;
      wr(ADDR_FRAME_DELAY, 24'h00040F);
      rd_chk(ADDR_FRAME_DELAY, 24'h00040F);
      wr(ADDR_SINGLE_SHOT, 24'h26AC0B);
      // a running continuous frame has to finish before a trigger is taken
      for (n = 0; n < 10 && acq_busy_r === 1'b1; n++) begin
         fe_strobe(s);
         tick(2);
      end
      chk(acq_busy_r, 24'h0);
      pulse(single_shot_trigger);
      n = 0;
      while (frame_start_strobe_r !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 400) begin
            chk(frame_start_strobe_r, 24'h1);
            close_out();
         end
      end
      chk(n, 166);
      chk(acq_busy_r, 24'h1);
      tick(2);
      fe_strobe(s);
      chk(s, 24'h1);
      tick(2);
      fe_strobe(s);
      chk(s, 24'h0);
      tick(2);
      chk(acq_busy_r, 24'h0);
      $display("test single_shot done");
   endtask

   // ten ticks of 25 ns come to about 25 system cycles
   task automatic t_freeze();
      int n;
      wr(ADDR_SINGLE_SHOT, 24'h000A0B);
      pulse(single_shot_trigger);
      for (n = 0; n < 40 && frozen_r !== 1'b1; n++) begin
         @(negedge sys_clk);
      end
      chk(frozen_r, 24'h1);
      chk(n >= 22 && n <= 28, 24'h1);
      $display("test freeze done");
   endtask

   // slots of 689h from the low end: 1 2 0 2 2 1
   task automatic t_rotation();
      logic s;
      wr(ADDR_SINGLE_SHOT, RST_SINGLE_SHOT);
      tick(3);
      wr(ADDR_CHANNEL_CTRL, 24'h983449);
      tick(2);
      for (int k = 0; k < 7; k++) begin
         fe_strobe(s);
         tick(2);
         chk(s, 24'h1);
         chk(emitter_select_r, (12'h689 >> (2 * (k % 6))) & 3);
      end
      $display("test rotation done");
   endtask

   // main sequence
   initial begin
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 24'h000000;
      single_shot_trigger = 1'b0;
      frame_end = 1'b0;
      amplitude = 16'h0000;
      amplitude_valid = 1'b0;
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      tick(1);
      t_reset();
      t_codes();
      t_auto();
      t_single();
      t_freeze();
      t_rotation();
      close_out();
   end
endmodule
